/* File: bench/pdg_board.sv */
// Board model: resolves each pad from port, board drivers and pull-ups
`timescale 1ns/1ps
module pdg_board (
    input wire logic clk,
    input wire logic [7:0] pinOut, pinOutEn, pullUpEn, extEn, extVal,
    output logic [7:0] pinIn
);
    logic [7:0] floatLvl = 8'h55;
    // Floating pads wander so a stale level never passes for a real one
    always @(posedge clk) floatLvl <= ~floatLvl;
    // Port driver first, then the board driver, then pull-up or float
    always_comb for (int i = 0; i < 8; i++)
        pinIn[i] = pinOutEn[i] ? pinOut[i] : extEn[i] ? extVal[i]
            : pullUpEn[i] | floatLvl[i];
endmodule

/* File: bench/pdg_port_monitor.sv */
// Assertion checker for the port's pad and register-bus outputs
`timescale 1ns/1ps
module pdg_port_monitor
    import pdg_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic ioWrite,
    input wire logic ioRead,
    input wire logic ioRdValid,
    input wire logic uartTxEn,
    input wire logic uartTxData,
    input wire logic uartRxEn,
    input wire logic [5:0] ioAddr,
    input wire logic [7:0] ioWrData,
    input wire logic [7:0] ioRdData,
    input wire logic [7:0] pinIn,
    input wire logic [7:0] pinOut,
    input wire logic [7:0] pinOutEn,
    input wire logic [7:0] pullUpEn
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    // Pads held still long enough for the synchroniser to catch up
    sequence s_pins_calm;
        pinIn == $past(pinIn) && pinIn == $past(pinIn, 2);
    endsequence
    sequence s_dir_wr;
        ioWrite && ioAddr == DIRECTION_ADDR && !uartTxEn && !uartRxEn;
    endsequence
    a_pull_vs_drive: assert property ((pullUpEn & pinOutEn) == 8'h00)
        else $error("pull-up on a driven pin");
    a_undriven_low: assert property ((pinOut & ~pinOutEn) == 8'h00)
        else $error("value on an undriven pin");
    a_rd_valid: assert property (ioRead |=> ioRdValid)
        else $error("read not answered");
    a_rd_idle: assert property (!ioRead |=> !ioRdValid &&
        ioRdData == 8'h00)
        else $error("read data outside a read");
    a_tx_force: assert property (uartTxEn |-> pinOutEn[1] &&
        pinOut[1] == uartTxData) else $error("transmit pin not forced");
    a_rx_input: assert property (uartRxEn |-> !pinOutEn[0])
        else $error("receive pin driven");
    a_rd_pins: assert property (ioRead && ioAddr == PIN_LEVEL_ADDR
        ##0 s_pins_calm |=> ioRdData == $past(pinIn))
        else $error("pin-level read wrong");
    a_dir_write: assert property (s_dir_wr |=> uartTxEn || uartRxEn ||
        pinOutEn == $past(ioWrData)) else $error("direction not applied");
endmodule

/* File: bench/pdg_port_tb_top.sv */
// Testbench top: register access, pad states and alternate functions
`timescale 1ns/1ps
module pdg_port_tb_top;
    import pdg_pkg::*;
    logic clk = 0, sys_rst = 1, ioWrite = 0, ioRead = 0, ioRdValid;
    logic uartTxEn = 0, uartTxData = 0, uartRxEn = 0, uartRxData;
    logic timer2CompareEn = 0, timer2CompareOut = 0, timer1CompareAEn = 0;
    logic timer1CompareAOut = 0, timer1CompareBEn = 0, timer1CompareBOut = 0;
    logic timer1CaptureEn = 0, extIrqOneEn = 0, extIrqZeroEn = 0;
    logic timer1CaptureIn, extIrqOne, extIrqZero;
    logic [5:0] ioAddr = 6'h00;
    logic [7:0] ioWrData = 8'h00, ioRdData, pinIn, pinOut, pinOutEn, pullUpEn;
    logic [7:0] extEn = 8'h00, extVal = 8'h00;
    logic [7:0] funcOuts;
    int num_errors = 0, tests_run = 0, cycles = 0;
    // Function levels gathered for one compare
    assign funcOuts = {4'h0, uartRxData, timer1CaptureIn, extIrqOne,
        extIrqZero};
    pdg_port pdg_port_inst (
        .clk(clk),
        .sys_rst(sys_rst),
        .ioAddr(ioAddr),
        .ioWrite(ioWrite),
        .ioRead(ioRead),
        .ioWrData(ioWrData),
        .ioRdData(ioRdData),
        .ioRdValid(ioRdValid),
        .pinIn(pinIn),
        .pinOut(pinOut),
        .pinOutEn(pinOutEn),
        .pullUpEn(pullUpEn),
        .timer2CompareEn(timer2CompareEn),
        .timer2CompareOut(timer2CompareOut),
        .timer1CompareAEn(timer1CompareAEn),
        .timer1CompareAOut(timer1CompareAOut),
        .timer1CompareBEn(timer1CompareBEn),
        .timer1CompareBOut(timer1CompareBOut),
        .timer1CaptureEn(timer1CaptureEn),
        .timer1CaptureIn(timer1CaptureIn),
        .extIrqOneEn(extIrqOneEn),
        .extIrqOne(extIrqOne),
        .extIrqZeroEn(extIrqZeroEn),
        .extIrqZero(extIrqZero),
        .uartTxEn(uartTxEn),
        .uartTxData(uartTxData),
        .uartRxEn(uartRxEn),
        .uartRxData(uartRxData)
    );
    pdg_board pdg_board_inst (
        .clk(clk),
        .pinOut(pinOut),
        .pinOutEn(pinOutEn),
        .pullUpEn(pullUpEn),
        .extEn(extEn),
        .extVal(extVal),
        .pinIn(pinIn)
    );
    initial forever #5 clk = ~clk;
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // One strobe cycle; a read compares the answer one cycle later
    task automatic acc(input logic [5:0] a, input logic [7:0] d, input bit rd);
        @(posedge clk);
        ioAddr <= a;
        ioWrData <= d;
        ioWrite <= !rd;
        ioRead <= rd;
        @(posedge clk);
        ioWrite <= 1'b0;
        ioRead <= 1'b0;
        #1;
        if (rd) chk(ioRdValid ? ioRdData : 8'hXX, d);
    endtask
    task automatic complete_run();
        if (num_errors == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // Hang guard, far above the fifty-odd cycles the sequence needs
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 500) begin
            num_errors++;
            complete_run();
        end
    end
    initial begin
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        #1 chk(pinOutEn | pullUpEn, 8'h00);
        acc(OUTPUT_LATCH_ADDR, 8'hFF, 0);
        chk(pullUpEn, 8'hFF);
        acc(OUTPUT_LATCH_ADDR, 8'hFF, 1);
        acc(DIRECTION_ADDR, 8'h0F, 0);
        chk(pinOutEn, 8'h0F);
        chk(pullUpEn, 8'hF0);
        chk(pinOut, 8'h0F);
        acc(DIRECTION_ADDR, 8'h0F, 1);
        acc(PIN_LEVEL_ADDR, 8'h00, 0);
        acc(OUTPUT_LATCH_ADDR, 8'hFF, 1);
        acc(6'h3F, 8'h00, 1);
        acc(OUTPUT_LATCH_ADDR, 8'h00, 0);
        chk(pullUpEn | pinOut, 8'h00);
        // Function enables change on a clock edge like all stimulus
        @(posedge clk);
        {timer2CompareEn, timer2CompareOut, timer1CompareAEn} <= 3'h7;
        {timer1CompareAOut, timer1CompareBEn, timer1CompareBOut} <= 3'h7;
        acc(DIRECTION_ADDR, 8'hF0, 0);
        chk(pinOut, 8'hB0);
        acc(DIRECTION_ADDR, 8'h70, 0);
        chk(pinOutEn & pinOut, 8'h30);
        @(posedge clk);
        {uartTxEn, uartTxData, uartRxEn} <= 3'h7;
        acc(DIRECTION_ADDR, 8'h00, 0);
        acc(OUTPUT_LATCH_ADDR, 8'h01, 0);
        chk(pinOutEn & pinOut, 8'h02);
        chk(pullUpEn, 8'h01);
        @(posedge clk);
        {uartTxEn, timer1CaptureEn, extIrqOneEn, extIrqZeroEn} <= 4'h7;
        extEn <= 8'hFF;
        extVal <= 8'h5C;
        repeat (3) @(posedge clk);
        acc(PIN_LEVEL_ADDR, 8'h5C, 1);
        chk(funcOuts, 8'h07);
        @(posedge clk);
        {uartRxEn, timer1CaptureEn, extIrqOneEn, extIrqZeroEn} <= 4'h0;
        repeat (4) @(posedge clk);
        #1 chk(funcOuts, 8'h08);
        complete_run();
    end
endmodule
bind pdg_port pdg_port_monitor pdg_port_monitor_inst (
    .clk(clk),
    .sys_rst(sys_rst),
    .ioWrite(ioWrite),
    .ioRead(ioRead),
    .ioRdValid(ioRdValid),
    .uartTxEn(uartTxEn),
    .uartTxData(uartTxData),
    .uartRxEn(uartRxEn),
    .ioAddr(ioAddr),
    .ioWrData(ioWrData),
    .ioRdData(ioRdData),
    .pinIn(pinIn),
    .pinOut(pinOut),
    .pinOutEn(pinOutEn),
    .pullUpEn(pullUpEn)
);

/* File: src/pdg_pkg.sv */
// Package with I/O addresses, field positions and reset values of the port
package pdg_pkg;
    localparam int PIN_COUNT = 8;
    localparam int IO_ADDR_WIDTH = 6;
    // I/O space locations of the three port addresses
    localparam logic [5:0] OUTPUT_LATCH_ADDR = 6'h12;
    localparam logic [5:0] DIRECTION_ADDR = 6'h11;
    localparam logic [5:0] PIN_LEVEL_ADDR = 6'h10;
    // Pin positions of the alternate functions
    localparam int PIN_RX = 0;
    localparam int PIN_TX = 1;
    localparam int PIN_IRQ0 = 2;
    localparam int PIN_IRQ1 = 3;
    localparam int PIN_T1B = 4;
    localparam int PIN_T1A = 5;
    localparam int PIN_CAPT = 6;
    localparam int PIN_T2 = 7;
    localparam logic [7:0] LATCH_RESET = 8'h00;
    localparam logic [7:0] DIRECTION_RESET = 8'h00;
    localparam logic [7:0] READ_IDLE = 8'h00;
    localparam int SYNC_STAGES = 2;
endpackage

/* File: src/pdg_port.sv */
// Eight-bit general purpose port with timer, interrupt and serial functions
`timescale 1ns/1ps
// Behaviour
// (RQ1) Direction bit one makes the pin an output, zero an input.
// (RQ2) Input pin with latch one gets its pull-up enabled.
// (RQ3) Pull-up off when latch is zero or pin is an output.
// (RQ4) Direction zero and latch zero leaves the pin floating.
// (RQ5) Output pin drives its latch value push-pull, no pull-up.
// (RQ6) Eight identical pins, seven down to zero, own bits each.
// (RQ7) Pin seven carries timer-two compare output when enabled and output.
// (RQ8) Pin six feeds timer-one capture when enabled and input.
// (RQ9) Pin five carries timer-one compare A when enabled and output.
// (RQ10) Pin four carries timer-one compare B when enabled and output.
// (RQ11) Pin three level goes to interrupt source one when enabled.
// (RQ12) Pin two level goes to interrupt source zero when enabled.
// (RQ13) Transmitter enabled forces pin one output with serial data.
// (RQ14) Receiver enabled forces pin zero to input whatever direction says.
// (RQ15) Forced input pin zero gets pull-up when its latch is one.
// (RQ16) Every pin input is synchronised to the core clock before use.
// (RQ17) Latch, direction, pin-level at I/O addresses 12h, 11h, 10h.
// (RQ18) Latch read returns latch, pin-level read returns pin values.
// (RQ19) Reset clears direction and latch, all pins floating inputs.
// (RQ20) Function enables are inputs; unenabled pins act as plain I/O.
module pdg_port #(
    // Pin count; the alternate-function map fixes it at eight
    parameter int PIN_COUNT = pdg_pkg::PIN_COUNT,
    // Synchroniser depth; the state record holds exactly two stages
    parameter int SYNC_DEPTH = pdg_pkg::SYNC_STAGES,
    // Address width of the I/O space decoder
    parameter int ADDR_WIDTH = pdg_pkg::IO_ADDR_WIDTH
) (
    // Clock and asynchronous reset
    input wire logic clk,
    input wire logic sys_rst,

    // Register access: strobes, address and data
    input wire logic [pdg_pkg::IO_ADDR_WIDTH-1:0] ioAddr,
    input wire logic ioWrite,
    input wire logic ioRead,
    input wire logic [7:0] ioWrData,
    output logic [7:0] ioRdData,
    output logic ioRdValid,

    // Pads: level seen, value driven, drive and pull-up enables
    input wire logic [7:0] pinIn,
    output logic [7:0] pinOut,
    output logic [7:0] pinOutEn,
    output logic [7:0] pullUpEn,

    // Timer compare outputs and capture input
    input wire logic timer2CompareEn,
    input wire logic timer2CompareOut,
    input wire logic timer1CompareAEn,
    input wire logic timer1CompareAOut,
    input wire logic timer1CompareBEn,
    input wire logic timer1CompareBOut,
    input wire logic timer1CaptureEn,
    output logic timer1CaptureIn,

    // External interrupt levels
    input wire logic extIrqOneEn,
    output logic extIrqOne,
    input wire logic extIrqZeroEn,
    output logic extIrqZero,

    // Serial transmitter and receiver
    input wire logic uartTxEn,
    input wire logic uartTxData,
    input wire logic uartRxEn,
    output logic uartRxData
);
    import pdg_pkg::*;

    // Widths here are fixed by the pin map and the package;
    // refuse sizes that the record and decoders cannot serve
    if (PIN_COUNT != 8) begin : g_pin_count_check
        $error("pdg_port: the alternate-function map needs eight pins");
    end
    if (SYNC_DEPTH != 2) begin : g_sync_depth_check
        $error("pdg_port: the state record holds two sync stages");
    end
    if (ADDR_WIDTH != IO_ADDR_WIDTH) begin : g_addr_width_check
        $error("pdg_port: the address port width is fixed");
    end
    // Every function pin must fall inside the port
    if (PIN_T2 >= PIN_COUNT) begin : g_pin_map_check
        $error("pdg_port: a function pin lies outside the port");
    end

    // Register record: latch and direction bits, two sync stages,
    // and the registered outputs; one flop bank for all of it
    typedef struct packed {
        logic [7:0] latch;
        logic [7:0] direction;
        logic [7:0] syncA;
        logic [7:0] syncB;
        logic [7:0] rdData;
        logic rdValid;
        logic captIn;
        logic irqOne;
        logic irqZero;
        logic rxData;
    } pdg_state_s;

    // Reset image; receive data idles high like a quiet serial line.
    // Latch and direction at zero leave every pin a floating input.
    localparam pdg_state_s STATE_RESET = '{
        latch: LATCH_RESET,
        direction: DIRECTION_RESET,
        syncA: 8'h00,
        syncB: 8'h00,
        rdData: READ_IDLE,
        rdValid: 1'b0,
        captIn: 1'b0,
        irqOne: 1'b0,
        irqZero: 1'b0,
        rxData: 1'b1
    };

    // One register bank; its next value is built in one block
    pdg_state_s state_q;
    pdg_state_s state_d;

    // Qualified address match, used by the latch and direction write decoders only.
    // A read and a write in one cycle see the old register value.
    function automatic logic addr_hit(
        input logic strobe,
        input logic [5:0] addr,
        input logic [5:0] target
    );
        return strobe && (addr == target);
    endfunction

    // Read multiplexer; unmapped addresses answer with the idle byte.
    // The direction register reads back so software can save it.
    function automatic logic [7:0] read_select(
        input logic [5:0] addr,
        input logic [7:0] latch,
        input logic [7:0] direction,
        input logic [7:0] pins
    );
        logic [7:0] res;
        res = READ_IDLE;
        case (addr)
            OUTPUT_LATCH_ADDR: begin
                res = latch; // RQ18
            end
            DIRECTION_ADDR: begin
                res = direction; // RQ17
            end
            PIN_LEVEL_ADDR: begin
                res = pins; // RQ18
            end
            default: begin
                // Unmapped location, nothing to report
                res = READ_IDLE;
            end
        endcase
        return res;
    endfunction

    // Input function gate; a disabled function sees a quiet low,
    // so the unit behind it never reacts to plain I/O traffic
    function automatic logic gate_input(
        input logic enable,
        input logic isInput,
        input logic level
    );
        logic res;
        res = 1'b0;
        if (enable && isInput) begin
            res = level;
        end
        return res;
    endfunction

    // Direction after the serial overrides
    function automatic logic [7:0] effective_dir(
        input logic [7:0] direction,
        input logic txEn,
        input logic rxEn
    );
        logic [7:0] res;
        res = direction; // RQ1 RQ6 RQ20
        // Transmitter claims pin one whatever its direction bit says
        if (txEn) begin
            res[PIN_TX] = 1'b1; // RQ13
        end
        // Receiver keeps pin zero an input so it never fights the line
        if (rxEn) begin
            res[PIN_RX] = 1'b0; // RQ14
        end
        // Both overrides may stand at once; they touch different pins
        return res;
    endfunction

    // Timer level takes the pin only while software made it an output;
    // otherwise the latch bit stands, as for a plain pin
    function automatic logic timer_pin(
        input logic enable,
        input logic dirBit,
        input logic timerLevel,
        input logic latchBit
    );
        logic res;
        res = latchBit;
        if (enable && dirBit) begin
            res = timerLevel;
        end
        return res;
    endfunction

    // Effective direction after the serial overrides
    logic [7:0] effDir;
    // Driven value after alternate function muxing
    logic [7:0] effOut;

    // Pin zero forced in by receiver, pin one forced out by transmitter
    always_comb begin
        effDir = effective_dir(state_q.direction, uartTxEn, uartRxEn);
    end

    // Timer outputs only take over while the pin is an output
    always_comb begin
        effOut = state_q.latch; // RQ5 RQ20
        effOut[PIN_T2] = timer_pin(timer2CompareEn,
            state_q.direction[PIN_T2], timer2CompareOut,
            state_q.latch[PIN_T2]); // RQ7
        effOut[PIN_T1A] = timer_pin(timer1CompareAEn,
            state_q.direction[PIN_T1A], timer1CompareAOut,
            state_q.latch[PIN_T1A]); // RQ9
        effOut[PIN_T1B] = timer_pin(timer1CompareBEn,
            state_q.direction[PIN_T1B], timer1CompareBOut,
            state_q.latch[PIN_T1B]); // RQ10
        // Transmit data overrides whatever the latch holds for pin one
        if (uartTxEn) begin
            effOut[PIN_TX] = uartTxData; // RQ13
        end
    end

    // Pads are combinational from the flops, so a write shows on
    // the pins right after the edge that takes it
    // Pad drive enables follow the effective direction
    assign pinOutEn = effDir; // RQ1 RQ4
    // Undriven pins show zero so a stale latch cannot leak out
    assign pinOut = effOut & effDir; // RQ5
    // Pull-up only on inputs, forced or not; never fights a driver
    assign pullUpEn = state_q.latch & ~effDir; // RQ2 RQ3 RQ4 RQ15

    // Next state: synchroniser, register writes, read data, functions
    always_comb begin
        state_d = state_q;
        // First stage feeds only the second, so a metastable level
        // never reaches the read or function paths directly
        state_d.syncA = pinIn; // RQ16
        state_d.syncB = state_q.syncA; // RQ16
        // Writes to the pin-level address are dropped, it is read-only
        if (addr_hit(ioWrite, ioAddr, OUTPUT_LATCH_ADDR)) begin
            state_d.latch = ioWrData; // RQ17
        end
        if (addr_hit(ioWrite, ioAddr, DIRECTION_ADDR)) begin
            state_d.direction = ioWrData; // RQ17
        end
        // Read answer stands one cycle; idle byte otherwise
        state_d.rdValid = ioRead;
        state_d.rdData = READ_IDLE;
        if (ioRead) begin
            state_d.rdData = read_select(ioAddr, state_q.latch,
                state_q.direction, state_q.syncB); // RQ17 RQ18
        end
        // Function inputs read synchronised levels only; one more flop
        // keeps them glitch free at the cost of a cycle of latency
        state_d.captIn = gate_input(timer1CaptureEn,
            !state_q.direction[PIN_CAPT], state_q.syncB[PIN_CAPT]); // RQ8
        state_d.irqOne = gate_input(extIrqOneEn, 1'b1,
            state_q.syncB[PIN_IRQ1]); // RQ11
        state_d.irqZero = gate_input(extIrqZeroEn, 1'b1,
            state_q.syncB[PIN_IRQ0]); // RQ12
        // Receive data idles high while the receiver is off
        state_d.rxData = uartRxEn ? state_q.syncB[PIN_RX] : 1'b1;
    end

    // Asynchronous reset loads only the constant reset image;
    // anything else here would race the release of reset
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q <= STATE_RESET; // RQ19
        end else begin
            state_q <= state_d;
        end
    end

    // Read answer straight from the state record
    assign ioRdData = state_q.rdData;
    assign ioRdValid = state_q.rdValid;
    // Function levels straight from the state record
    assign timer1CaptureIn = state_q.captIn;
    assign extIrqOne = state_q.irqOne;
    assign extIrqZero = state_q.irqZero;
    assign uartRxData = state_q.rxData;
endmodule
